// ### include/tscp_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TSCP_CONSTS_SVH
`define TSCP_CONSTS_SVH
`define TSCP_OFF_CMD_ONE 8'h00
`define TSCP_OFF_CMD_TWO 8'h04
`define TSCP_OFF_SLOT_VALUE 8'h08
`define TSCP_OFF_SRC_PORT 8'h0c
`define TSCP_OFF_DST_PORT 8'h10
`define TSCP_OFF_IN_SLOT 8'h14
`define TSCP_OFF_OUT_SLOT 8'h18
`define TSCP_OFF_CONN_CMD 8'h1c
`define TSCP_OFF_GP_LOW 8'h20
`define TSCP_OFF_GP_HIGH 8'h24
`define TSCP_OFF_PACKED_SRC 8'h28
`define TSCP_OFF_PACKED_DST 8'h2c
`define TSCP_OFF_WIDE_CONN 8'h30
`define TSCP_OFF_WIDE_GP 8'h34
`define TSCP_OFF_STATUS 8'h38
`define TSCP_CMD_PCM_SEL 4'h2
`define TSCP_CMD_STANDBY 4'h4
`define TSCP_CMD_RATE 4'hb
`define TSCP_CMD_READ_SLOT 8'h0d
`define TSCP_CMD_IN_SHIFT 8'h0f
`define TSCP_CMD_OUT_SHIFT 8'h2f
`define TSCP_CMD_FRAME 4'h6
`define TSCP_CONN_SET 8'h01
`define TSCP_CONN_REL 8'h05
`define TSCP_PORT_BP_BIT 7
`define TSCP_SLOTS_2M 8'd32
`define TSCP_FRAME_NS 125000
`define TSCP_CLK_NS 8
`define TSCP_FRAME_CYC (`TSCP_FRAME_NS / `TSCP_CLK_NS)
`define TSCP_TIMEOUT_FRAMES 3
`define TSCP_PULSE_NS 61
`define TSCP_RATE_RESET 2'd0
`define TSCP_LINES 16
`endif

// ### include/tscp_pkg.sv
// Types shared by the command block
package tscp_pkg;
	typedef enum logic [1:0] {TSCP_RATE_2M, TSCP_RATE_4M, TSCP_RATE_8M,
		TSCP_RATE_16M} tscp_rate_t;
	typedef struct packed
	{
		logic is_backplane;
		logic [6:0] line;
	} tscp_port_t;
	typedef struct packed
	{
		logic valid;
		tscp_port_t src;
		logic [7:0] in_slot;
		tscp_port_t dst;
		logic [7:0] out_slot;
		logic release_conn;
	} tscp_conn_t;
	typedef struct packed
	{
		logic [7:0] start_cycle;
		logic falling_edge;
		logic [7:0] length;
	} tscp_frame_t;
endpackage : tscp_pkg

// ### rtl/tscp_cmd.sv
// Host command interpreter for the slot switching device
// Operation
// RULE_01 - Host ends clock changes with master/slave command
// RULE_02 - Host programs backplane clocking before PCM clocking
// RULE_03 - PCM clocks internal as master, external as slave
// RULE_04 - All line outputs tristated after reset
// RULE_05 - Standby toggles lines; switching keeps running
// RULE_06 - Host sets pcm-only flag for PCM tristate
// RULE_07 - Reset rate 2.048 Mbit/s; range command tunes
// RULE_08 - Host loads ports before set-bit-rate command
// RULE_09 - Shifts counted in half-bit steps
// RULE_10 - Double clock: bit is two clocks
// RULE_11 - Input shift per line, output shift global
// RULE_12 - Frame pulse: chosen edge, cycle, 61 ns multiples
// RULE_13 - Read slot captured, interrupt, new read accepted
// RULE_14 - Each read reissued; new read overwrites result
// RULE_15 - Host loads line, slot, then writes 0D
// RULE_16 - Invalid slot: no interrupt, commands refused
// RULE_17 - Time-out releases stalled read within three frames
// RULE_18 - Connections programmable while switching runs
// RULE_19 - Host releases old connection before new one
// RULE_20 - Connection via 01 or wide 0001 command
// RULE_21 - Host reads result before next slot read
// RULE_22 - Port byte top bit marks backplane line
`include "tscp_consts.svh"
module tscp_cmd
(
	input wire logic clk_in, // 125 MHz clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic [7:0] avs_address_in, // Byte address
	input wire logic avs_read_in, // Read request
	input wire logic avs_write_in, // Write request
	input wire logic [31:0] avs_writedata_in, // Write data
	output logic [31:0] avs_readdata_out, // Read data
	output logic avs_waitrequest_out, // Stall
	input wire logic frame_sync_in, // Frame pulse from line side
	input wire logic [7:0] line_slot_in, // Slot index now on line
	input wire logic [7:0] line_data_in, // Slot data now on line
	input wire logic [7:0] line_port_in, // Port of line data
	output logic backplane_oe_out, // Backplane outputs enabled
	output logic pcm_oe_out, // PCM outputs enabled
	output logic pcm_clock_master_out, // PCM clocks from PLL
	output logic [3:0] pcm_gi_out, // PCM clock parameter
	output logic [1:0] range_out, // Data rate range
	output logic [1:0] in_rate_out [`TSCP_LINES], // Input rates
	output logic [1:0] out_rate_out [`TSCP_LINES], // Output rates
	output logic [3:0] in_shift_out [`TSCP_LINES], // Half-bit shifts
	output logic [3:0] out_shift_out, // Half-bit shift, all outputs
	output logic [4:0] in_shift_clk_out, // Shift in clocks, line 0
	output tscp_pkg::tscp_frame_t frame_cfg_out [2], // Pulse setup
	output logic [15:0] pulse_ns_out [2], // Pulse length in ns
	output tscp_pkg::tscp_conn_t conn_out, // Connection request
	output logic slot_read_irq_out // Slot read done pulse
);
	logic [7:0] src_port; // Source port
	logic [7:0] dst_port; // Destination port
	logic [7:0] in_slot; // Input slot
	logic [7:0] out_slot; // Output slot
	logic [7:0] gp_low; // General parameter low
	logic [7:0] gp_high; // General parameter high
	logic [7:0] slot_value; // Captured slot value
	logic read_busy; // Read pending
	logic read_bad; // Pending read invalid
	logic [20:0] timeout_cnt; // Time-out cycle counter
	logic sync1, sync2, sync3; // Frame sync synchroniser
	logic [7:0] slot_s1, slot_s2, data_s1, data_s2; // Line sync
	logic [7:0] port_s1, port_s2; // Port sync
	logic double_clk; // Data clock at twice rate
	logic wr, rd; // Bus strobes
	logic cmd_one_wr; // Write to first command register
	logic [7:0] wbyte; // Low write byte
	logic [8:0] max_slot; // Slots for selected line rate, up to 256

	// Strobes; slave answers in the request cycle
	assign wr = avs_write_in;
	assign rd = avs_read_in;
	assign wbyte = avs_writedata_in[7:0];
	assign avs_waitrequest_out = 1'b0;
	assign cmd_one_wr = wr && avs_address_in == `TSCP_OFF_CMD_ONE
		&& !read_busy; // RULE_16
	assign double_clk = gp_high[7];

	// Input synchronisers for line-side signals
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			slot_s1 <= 8'h00;
			slot_s2 <= 8'h00;
			data_s1 <= 8'h00;
			data_s2 <= 8'h00;
			port_s1 <= 8'h00;
			port_s2 <= 8'h00;
		end
		else
		begin
			sync1 <= frame_sync_in;
			sync2 <= sync1;
			sync3 <= sync2;
			slot_s1 <= line_slot_in;
			slot_s2 <= slot_s1;
			data_s1 <= line_data_in;
			data_s2 <= data_s1;
			port_s1 <= line_port_in;
			port_s2 <= port_s1;
		end
	end

	// Address and parameter registers, byte and packed forms
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			src_port <= 8'h00;
			dst_port <= 8'h00;
			in_slot <= 8'h00;
			out_slot <= 8'h00;
			gp_low <= 8'h00;
			gp_high <= 8'h00;
		end
		else if (wr)
		begin
			case (avs_address_in)
				`TSCP_OFF_SRC_PORT: src_port <= wbyte;
				`TSCP_OFF_DST_PORT: dst_port <= wbyte;
				`TSCP_OFF_IN_SLOT: in_slot <= wbyte;
				`TSCP_OFF_OUT_SLOT: out_slot <= wbyte;
				`TSCP_OFF_GP_LOW: gp_low <= wbyte;
				`TSCP_OFF_GP_HIGH: gp_high <= wbyte;
				`TSCP_OFF_PACKED_SRC: // Slot high byte, port low
				begin
					src_port <= wbyte;
					in_slot <= avs_writedata_in[15:8];
				end
				`TSCP_OFF_PACKED_DST:
				begin
					dst_port <= wbyte;
					out_slot <= avs_writedata_in[15:8];
				end
				`TSCP_OFF_WIDE_GP:
				begin
					gp_low <= wbyte;
					gp_high <= avs_writedata_in[15:8];
				end
				default: ;
			endcase
		end
	end

	// Standby and PCM clock selection from the first command register
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			backplane_oe_out <= 1'b0; // RULE_04
			pcm_oe_out <= 1'b0; // RULE_04
			pcm_clock_master_out <= 1'b0;
			pcm_gi_out <= 4'h0;
		end
		else if (cmd_one_wr)
		begin
			case (wbyte[3:0])
				`TSCP_CMD_STANDBY: // Bit 5 tristates, gp bit 0 PCM only
				begin
					pcm_oe_out <= !wbyte[5]; // RULE_05
					if (!gp_low[0])
						backplane_oe_out <= !wbyte[5]; // RULE_05
				end
				`TSCP_CMD_PCM_SEL: // Bit 4 set selects master
				begin
					pcm_clock_master_out <= wbyte[4]; // RULE_03
					pcm_gi_out <= gp_low[3:0]; // RULE_03
				end
				default: ;
			endcase
		end
	end

	// Rate range, data rates and input shifts per line, output shift for all lines
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			range_out <= `TSCP_RATE_RESET; // RULE_07
			out_shift_out <= 4'h0;
			for (int i = 0; i < `TSCP_LINES; i++)
			begin
				in_rate_out[i] <= `TSCP_RATE_RESET; // RULE_07
				out_rate_out[i] <= `TSCP_RATE_RESET;
				in_shift_out[i] <= 4'h0;
			end
		end
		else
		begin
			if (wr && avs_address_in == `TSCP_OFF_CMD_TWO && !read_busy
				&& wbyte[3:0] == 4'h8)
				range_out <= wbyte[5:4]; // RULE_07
			if (cmd_one_wr && wbyte[3:0] == `TSCP_CMD_RATE)
			begin
				in_rate_out[src_port[3:0]] <= wbyte[7:6]; // RULE_08
				out_rate_out[dst_port[3:0]] <= wbyte[5:4];
			end
			if (cmd_one_wr && wbyte == `TSCP_CMD_IN_SHIFT)
				in_shift_out[src_port[3:0]] <= gp_low[3:0]; // RULE_11
			if (cmd_one_wr && wbyte == `TSCP_CMD_OUT_SHIFT)
				out_shift_out <= gp_low[3:0]; // RULE_11
		end
	end

	// Half-bit shift to clocks: half bit is one clock at double rate
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			in_shift_clk_out <= 5'h00;
		else if (double_clk)
			in_shift_clk_out <= {1'b0, in_shift_out[0]}; // RULE_10
		else
			in_shift_clk_out <= {2'b00, in_shift_out[0][3:1]}; // RULE_09
	end

	// Frame pulse setup from general parameters and second command
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			for (int i = 0; i < 2; i++)
			begin
				frame_cfg_out[i] <= '0;
				pulse_ns_out[i] <= 16'h0000;
			end
		else if (wr && avs_address_in == `TSCP_OFF_CMD_TWO && !read_busy
			&& wbyte[3:0] == `TSCP_CMD_FRAME && wbyte[7:4] != 4'h0
			&& wbyte[7:4] < 4'h3)
		begin
			frame_cfg_out[wbyte[4] ? 0 : 1].start_cycle <=
				{gp_high[4:0], gp_low[7:5]}; // RULE_12
			frame_cfg_out[wbyte[4] ? 0 : 1].falling_edge <= gp_low[4];
			frame_cfg_out[wbyte[4] ? 0 : 1].length <= {5'h00, gp_high[7:5]};
			// Length code n stands for n+1 units of the pulse step
			pulse_ns_out[wbyte[4] ? 0 : 1] <=
				16'(({1'b0, gp_high[7:5]} + 4'h1)
				* `TSCP_PULSE_NS); // RULE_12
		end
	end

	// Slot read: capture, interrupt, time-out
	always_comb
	begin
		// Nine bits so that 256 slots at the top rate do not wrap to 0
		max_slot = 9'(`TSCP_SLOTS_2M) << in_rate_out[src_port[3:0]];
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			read_busy <= 1'b0;
			read_bad <= 1'b0;
			slot_value <= 8'h00;
			timeout_cnt <= 21'h0;
			slot_read_irq_out <= 1'b0;
		end
		else
		begin
			slot_read_irq_out <= 1'b0;
			if (cmd_one_wr && wbyte == `TSCP_CMD_READ_SLOT)
			begin
				read_busy <= 1'b1; // RULE_14
				read_bad <= in_slot >= max_slot; // RULE_16
				slot_value <= 8'h00; // RULE_14
				timeout_cnt <= 21'h0;
			end
			else if (read_busy)
			begin
				timeout_cnt <= timeout_cnt + 21'h1;
				if (!read_bad && slot_s2 == in_slot && port_s2 == src_port)
				begin
					slot_value <= data_s2; // RULE_13
					slot_read_irq_out <= 1'b1; // RULE_13
					read_busy <= 1'b0;
				end
				else if (timeout_cnt == 21'(`TSCP_TIMEOUT_FRAMES
					* `TSCP_FRAME_CYC - 1))
					read_busy <= 1'b0; // RULE_17
			end
		end
	end

	// Connection requests, accepted while switching continues
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			conn_out <= '0;
		else
		begin
			conn_out.valid <= 1'b0;
			if (wr && !read_busy && ((avs_address_in == `TSCP_OFF_CONN_CMD
				&& (wbyte == `TSCP_CONN_SET || wbyte == `TSCP_CONN_REL))
				|| (avs_address_in == `TSCP_OFF_WIDE_CONN
				&& avs_writedata_in[15:8] == 8'h00
				&& (wbyte == `TSCP_CONN_SET || wbyte == `TSCP_CONN_REL))))
			begin
				conn_out.valid <= 1'b1; // RULE_18
				conn_out.src <= src_port; // RULE_22
				conn_out.dst <= dst_port; // RULE_22
				conn_out.in_slot <= in_slot; // RULE_20
				conn_out.out_slot <= out_slot;
				conn_out.release_conn <= wbyte == `TSCP_CONN_REL;
			end
		end
	end

	// Read data mux; unmapped reads as zero, idle bus as unmapped
	always_comb
	begin
		case (rd ? avs_address_in : 8'hff)
			`TSCP_OFF_SLOT_VALUE: avs_readdata_out = {24'h0, slot_value};
			`TSCP_OFF_SRC_PORT: avs_readdata_out = {24'h0, src_port};
			`TSCP_OFF_DST_PORT: avs_readdata_out = {24'h0, dst_port};
			`TSCP_OFF_IN_SLOT: avs_readdata_out = {24'h0, in_slot};
			`TSCP_OFF_OUT_SLOT: avs_readdata_out = {24'h0, out_slot};
			`TSCP_OFF_GP_LOW: avs_readdata_out = {24'h0, gp_low};
			`TSCP_OFF_GP_HIGH: avs_readdata_out = {24'h0, gp_high};
			`TSCP_OFF_STATUS: avs_readdata_out = {27'h0, sync3, read_bad,
				read_busy, backplane_oe_out, pcm_oe_out};
			default: avs_readdata_out = 32'h0;
		endcase
	end
endmodule : tscp_cmd

// ### tb/tdm_switch_command_programming_tb_top.sv
// Self-checking bench for the command block
`include "tscp_consts.svh"
module tdm_switch_command_programming_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [7:0] avs_address_in = 8'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rv;
	logic avs_waitrequest_out, backplane_oe_out, pcm_oe_out;
	logic pcm_clock_master_out, frame_sync_in, slot_read_irq_out;
	logic [7:0] line_slot_in, line_data_in, line_port_in;
	logic [7:0] sel_port = 8'h03; // Port shown by the stand-in
	logic [3:0] pcm_gi_out, out_shift_out, in_shift_out [`TSCP_LINES];
	logic [1:0] range_out, in_rate_out [`TSCP_LINES];
	logic [1:0] out_rate_out [`TSCP_LINES];
	logic [4:0] in_shift_clk_out;
	logic [15:0] pulse_ns_out [2];
	tscp_pkg::tscp_frame_t frame_cfg_out [2];
	tscp_pkg::tscp_conn_t conn_out, conn_seen;
	int err_total = 0, total_checks = 0, irqs = 0, conns = 0;
	tscp_cmd i_tscp_cmd (.clk_in, .reset_n_in, .avs_address_in,
		.avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
		.avs_waitrequest_out, .frame_sync_in, .line_slot_in, .line_data_in,
		.line_port_in, .backplane_oe_out, .pcm_oe_out, .pcm_clock_master_out,
		.pcm_gi_out, .range_out, .in_rate_out, .out_rate_out, .in_shift_out,
		.out_shift_out, .in_shift_clk_out, .frame_cfg_out, .pulse_ns_out,
		.conn_out, .slot_read_irq_out);
	tscp_line_model i_tscp_line_model (.clk_in, .reset_n_in,
		.port_in(sel_port), .frame_sync_out(frame_sync_in),
		.slot_out(line_slot_in), .data_out(line_data_in),
		.port_out(line_port_in));
	initial forever #4 clk_in = ~clk_in;
	// Count read-done and connection strobes
	always @(posedge clk_in)
	begin
		if (slot_read_irq_out === 1'b1) irqs++;
		if (conn_out.valid === 1'b1) conn_seen = conn_out;
		if (conn_out.valid === 1'b1) conns++;
	end
	task automatic chk(input string n, input logic [39:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Bus write, held until waitrequest is seen low
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= 1'b1;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
		avs_write_in <= 1'b0;
		@(posedge clk_in);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
		rv = avs_readdata_out;
		avs_read_in <= 1'b0;
		@(posedge clk_in);
	endtask : rd
	// Connection command, then the strobe within 20 clocks
	task automatic conn(input logic [7:0] a, input logic [31:0] d, input r);
		int k;
		k = conns;
		conn_seen = '0;
		wr(a, d);
		repeat (20) if (conns == k) @(posedge clk_in);
		chk("conn", {1'b1, 8'h03, 8'h0a, 8'h96, 8'h1e, r}, conn_seen);
	endtask : conn
	// Slot read: value and done strobe within 400 clocks
	task automatic rdslot(input logic [7:0] s);
		int k;
		wr(8'h14, s);
		k = irqs;
		wr(8'h00, 8'h0d);
		repeat (400) if (irqs == k) @(posedge clk_in);
		chk("irq", 1, irqs - k);
		rd(8'h08);
		chk("slot value", s ^ 8'h5a, rv);
	endtask : rdslot
	task automatic fin(input string s);
		$display("%s done, errors %0d", s, err_total);
	endtask : fin
	task automatic conclude;
		$display("checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic t_basic;
		chk("pcm oe", 0, pcm_oe_out);
		chk("bp oe", 0, backplane_oe_out);
		for (int i = 0; i < 16; i++) chk("rate", 0, in_rate_out[i]);
		rd(8'h3c);
		chk("unmapped", 0, rv);
		wr(8'h20, 0);
		wr(8'h00, 8'h04);
		chk("pcm on", 1, pcm_oe_out);
		wr(8'h20, 1);
		wr(8'h00, 8'h24);
		chk("pcm off", 0, pcm_oe_out);
		chk("bp kept", 1, backplane_oe_out);
		wr(8'h00, 8'h12);
		chk("master", 1, pcm_clock_master_out);
		chk("pcm gi", 1, pcm_gi_out);
		wr(8'h00, 8'h02);
		chk("slave", 0, pcm_clock_master_out);
		fin("basic");
	endtask : t_basic
	task automatic t_lines;
		wr(8'h04, 8'h38);
		chk("range", 3, range_out);
		wr(8'h0c, 8'h08);
		wr(8'h10, 8'h01);
		wr(8'h00, 8'h5b);
		chk("in rate", 1, in_rate_out[8]);
		chk("out rate", 1, out_rate_out[1]);
		chk("other rate", 0, in_rate_out[9]);
		wr(8'h20, 8'h08);
		wr(8'h00, 8'h0f);
		chk("in shift", 8, in_shift_out[8]);
		chk("other shift", 0, in_shift_out[3]);
		wr(8'h20, 8'h01);
		wr(8'h00, 8'h2f);
		chk("out shift", 1, out_shift_out);
		wr(8'h0c, 8'h00);
		wr(8'h20, 8'h02);
		wr(8'h24, 8'h00);
		wr(8'h00, 8'h0f);
		@(posedge clk_in); // Shift in clocks trails the shift by one
		chk("bit clocks", 1, in_shift_clk_out);
		wr(8'h24, 8'h80);
		wr(8'h00, 8'h0f);
		@(posedge clk_in); // Shift in clocks trails the shift by one
		chk("double clocks", 2, in_shift_clk_out);
		wr(8'h20, 8'h00);
		wr(8'h24, 8'h61);
		wr(8'h04, 8'h16);
		chk("pulse one", 244, pulse_ns_out[0]);
		chk("edge one", 0, frame_cfg_out[0].falling_edge);
		wr(8'h34, 32'hc012); // Wide form: high byte, then low byte
		wr(8'h04, 8'h26);
		chk("pulse two", 427, pulse_ns_out[1]);
		chk("edge two", 1, frame_cfg_out[1].falling_edge);
		fin("lines");
	endtask : t_lines
	task automatic t_conn;
		wr(8'h14, 8'h0a);
		wr(8'h0c, 8'h03);
		wr(8'h18, 8'h1e);
		wr(8'h10, 8'h96);
		conn(8'h1c, 8'h01, 1'b0);
		conn(8'h1c, 8'h05, 1'b1);
		wr(8'h28, 32'h0a03);
		wr(8'h2c, 32'h1e96);
		conn(8'h30, 32'h0001, 1'b0);
		conn(8'h30, 32'h0005, 1'b1);
		fin("connections");
	endtask : t_conn
	task automatic t_read;
		int k, c, n;
		wr(8'h0c, 8'h03);
		rdslot(8'h0a);
		rdslot(8'h1f);
		wr(8'h14, 8'h3a);
		k = irqs;
		c = conns;
		wr(8'h00, 8'h0d);
		wr(8'h1c, 8'h01);
		repeat (46000) @(posedge clk_in);
		chk("bad irq", 0, irqs - k);
		chk("refused", 0, conns - c);
		rd(8'h38);
		chk("busy", 1, rv[2]);
		n = 0;
		do rd(8'h38); while (rv[2] === 1'b1 && ++n < 1000);
		chk("released", 0, rv[2]);
		rdslot(8'h05);
		fin("slot read");
	endtask : t_read
	initial
	begin
		repeat (3) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		t_basic;
		t_lines;
		t_conn;
		t_read;
		conclude;
	end
	initial
	begin
		repeat (60000) @(posedge clk_in);
		err_total++;
		conclude;
	end
endmodule : tdm_switch_command_programming_tb_top

// ### tb/tscp_cmd_props.sv
// Port-level assertions on the command block
module tscp_cmd_props
(
	input wire logic clk_in, // Clock
	input wire logic reset_n_in, // Reset, active low
	input wire logic [7:0] avs_address_in, // Address
	input wire logic avs_write_in, // Write
	input wire logic [31:0] avs_writedata_in, // Write data
	input wire logic pcm_oe_out, // PCM enable
	input wire logic backplane_oe_out, // Backplane enable
	input wire logic pcm_clock_master_out, // Clock master
	input wire logic [1:0] range_out, // Rate range
	input wire logic [3:0] out_shift_out, // Output shift
	input wire tscp_pkg::tscp_conn_t conn_out, // Connection
	input wire logic slot_read_irq_out // Read done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr1; // Write to the first command register
	assign wr1 = avs_write_in && avs_address_in == 8'h00;
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// Standby command, t is the tristate bit
	sequence sby(t);
		wr1 && avs_writedata_in[3:0] == 4'h4 && avs_writedata_in[5] == t;
	endsequence
	// Full command code on the first register
	sequence code1(c);
		wr1 && avs_writedata_in[7:0] == c;
	endsequence
	oe_reset_a: assert property (
		$rose(reset_n_in) |-> !pcm_oe_out && !backplane_oe_out)
		else $error("lines enabled at reset");
	oe_cause_a: assert property (
		$rose(pcm_oe_out) || $rose(backplane_oe_out) |-> $past(wr1))
		else $error("lines enabled without command");
	sby_on_a: assert property (sby(1'b0) |=> pcm_oe_out)
		else $error("standby enable ignored");
	sby_off_a: assert property (sby(1'b1) |=> !pcm_oe_out)
		else $error("standby tristate ignored");
	rate_reset_a: assert property (
		$rose(reset_n_in) |-> range_out == 2'h0)
		else $error("range not reset");
	master_sel_a: assert property (
		$changed(pcm_clock_master_out) |->
		$past(wr1 && avs_writedata_in[3:0] == 4'h2))
		else $error("clock master changed without command");
	out_shift_a: assert property (
		$changed(out_shift_out) |->
		$past(wr1 && avs_writedata_in[7:0] == 8'h2f))
		else $error("output shift changed without command");
	read_wait_a: assert property (
		code1(8'h0d) |=> !slot_read_irq_out)
		else $error("read done before slot arrived");
	conn_pulse_a: assert property (
		conn_out.valid |=> !conn_out.valid)
		else $error("connection strobe too long");
endmodule : tscp_cmd_props
bind tscp_cmd tscp_cmd_props i_tscp_cmd_props (.clk_in, .reset_n_in,
	.avs_address_in, .avs_write_in, .avs_writedata_in, .pcm_oe_out,
	.backplane_oe_out, .pcm_clock_master_out, .range_out, .out_shift_out,
	.conn_out, .slot_read_irq_out);

// ### tb/tscp_line_model.sv
// Line side stand-in: one port, 32 slots, four clocks a slot
module tscp_line_model
(
	input wire logic clk_in, // Clock
	input wire logic reset_n_in, // Reset, active low
	input wire logic [7:0] port_in, // Port to present
	output logic frame_sync_out, // Frame start
	output logic [7:0] slot_out, // Slot index
	output logic [7:0] data_out, // Slot data
	output logic [7:0] port_out // Port of the data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] sub; // Clocks within a slot
	// Slot counter wraps after slot 31, the last one at 2.048M
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			sub <= 2'h0;
			slot_out <= 8'h00;
		end
		else
		begin
			sub <= sub + 2'h1;
			if (sub == 2'h3)
				slot_out <= (slot_out == 8'h1f) ? 8'h00 : slot_out + 8'h01;
		end
	assign frame_sync_out = slot_out == 8'h00; // Pulse on slot 0
	assign data_out = slot_out ^ 8'h5a; // Pattern known to the bench
	assign port_out = port_in;
endmodule : tscp_line_model
